/* File: hdl/mcfh_buf.sv */
// Small shift-style FIFO with registered outputs
`timescale 1ns/1ns

module mcfh_buf
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)
(
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output wire logic             in_ready,
	output wire logic             out_valid,
	output wire logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    count_d;
	logic [CW-1:0]    wr_idx;
	logic             valid_q;
	logic             push;
	logic             pop;

	// Head always sits in entry 0, so the output is a flop
	assign in_ready  = (count_q != CW'(DEPTH));
	assign push      = in_valid && in_ready;
	assign pop       = valid_q && out_ready;
	assign out_valid = valid_q;
	assign out_data  = mem_q[0];

	// Occupancy and write slot after a possible pop
	always_comb
	begin
		count_d = count_q;
		wr_idx  = count_q;
		if (pop)
		begin
			wr_idx = count_q - 1'b1;
		end
		if (push && !pop)
		begin
			count_d = count_q + 1'b1;
		end
		else if (pop && !push)
		begin
			count_d = count_q - 1'b1;
		end
	end

	// Per-entry next value: shift on pop, then write
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_entry
		always_comb
		begin
			mem_d[i] = mem_q[i];
			if (pop)
			begin
				if (i == DEPTH - 1)
				begin
					mem_d[i] = mem_q[i];
				end
				else
				begin
					mem_d[i] = mem_q[(i + 1) % DEPTH];
				end
			end
			if (push && (wr_idx == CW'(i)))
			begin
				mem_d[i] = in_data;
			end
		end
	end

	// Register stage
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			count_q <= '0;
			valid_q <= 1'b0;
			for (int k = 0; k < DEPTH; k++)
			begin
				mem_q[k] <= '0;
			end
		end
		else
		begin
			count_q <= count_d;
			valid_q <= (count_d != '0);
			mem_q   <= mem_d;
		end
	end

	// Occupancy never passes the depth
	a_buf_bound: assert property (@(posedge clock) disable iff (sys_rst)
		(count_q <= CW'(DEPTH)) && (valid_q == (count_q != '0)))
		else $error("buffer occupancy out of range");

endmodule // mcfh_buf

/* File: hdl/mcfh_cfg.svh */
// Frame lengths, byte positions and status codes of the command frame handler
`ifndef MCFH_CFG_SVH
`define MCFH_CFG_SVH

// ----------------------------------------------------------------------
// Frame lengths in bytes
// ----------------------------------------------------------------------
`define MCFH_SER_LEN      4'h9
`define MCFH_CAN_LEN      4'h7
`define MCFH_SER_RLEN     4'h9
`define MCFH_CAN_RLEN     4'h6
// Serial frame positions of address and checksum
`define MCFH_POS_ADDR     4'h0
`define MCFH_POS_SUM      4'h8
// Reply bytes skipped on the CAN link (reply and module address)
`define MCFH_CAN_RSKIP    4'h2

// ----------------------------------------------------------------------
// Reply status codes
// ----------------------------------------------------------------------
`define MCFH_ST_OK        8'h64
`define MCFH_ST_STORED    8'h65
`define MCFH_ST_BAD_SUM   8'h01
`define MCFH_ST_BAD_CMD   8'h02
`define MCFH_ST_BAD_TYPE  8'h03
`define MCFH_ST_BAD_VALUE 8'h04
`define MCFH_ST_LOCKED    8'h05
`define MCFH_ST_NO_CMD    8'h06

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MCFH_RST_BYTE     8'h00
`define MCFH_RST_WORD     32'h0000_0000

`endif

/* File: hdl/mcfh_pkg.sv */
// Types shared by the command frame handler
package mcfh_pkg;

	// Decoded command body
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  kind;
		logic [7:0]  bank;
		logic [31:0] value;
	} mcfh_cmd_t;

	// Result handed back by the executor
	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] value;
	} mcfh_rsp_t;

	typedef enum logic [1:0] {
		MCFH_RX,
		MCFH_EXEC,
		MCFH_TX
	} mcfh_state_t;

endpackage

/* File: hdl/mcfh_top.sv */
// Command frame receiver, executor handshake and reply framer
`timescale 1ns/1ns
`include "mcfh_cfg.svh"
// Operation
// (R1) Command body: command, type, motor/bank, four value bytes MSB first.
// (R2) Serial frames add a leading address byte and trailing checksum: nine bytes.
// (R3) Command checksum is the 8-bit sum of the first eight frame bytes.
// (R4) On CAN no address or checksum byte; identifier and CRC take over.
// (R5) Each received command gets exactly one reply frame.
// (R6) Reply goes out only after the command has finished executing.
// (R7) Serial reply: reply addr, module addr, status, command, value, checksum.
// (R8) Reply checksum is the wrapping 8-bit sum of all earlier reply bytes.
// (R9) On CAN the reply drops address and checksum bytes.
// (R10) Status 100 ok, 101 stored, 1..6 the listed error codes.
// (R11) Device never transmits except when answering a received command.
// (R12) Host waits for the reply before sending the next command.
// (R13) Strict master and slave: host starts, device only answers.
// (R14) Reply echoes the received command number.
// (R15) Serial frames for another address are dropped without reply.

module mcfh_top
(
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               can_mode,
	input  wire logic [7:0]         own_addr,
	input  wire logic [7:0]         reply_addr,
	input  wire logic               rx_valid,
	input  wire logic [7:0]         rx_data,
	output wire logic               rx_ready,
	output wire logic               exec_req,
	output mcfh_pkg::mcfh_cmd_t     exec_cmd,
	input  wire logic               exec_done,
	input  mcfh_pkg::mcfh_rsp_t     exec_rsp,
	output wire logic               tx_valid,
	output wire logic [7:0]         tx_data,
	input  wire logic               tx_ready,
	output wire logic               busy
);
	mcfh_pkg::mcfh_state_t state_q;
	mcfh_pkg::mcfh_state_t state_d;
	mcfh_pkg::mcfh_cmd_t   cmd_q;
	mcfh_pkg::mcfh_cmd_t   cmd_d;
	mcfh_pkg::mcfh_rsp_t   rsp_q;
	mcfh_pkg::mcfh_rsp_t   rsp_d;
	logic [3:0]            rx_pos_q;
	logic [3:0]            rx_pos_d;
	logic [7:0]            rx_sum_q;
	logic [7:0]            rx_sum_d;
	logic [7:0]            addr_q;
	logic [7:0]            addr_d;
	logic [3:0]            tx_idx_q;
	logic [3:0]            tx_idx_d;
	logic [7:0]            tx_sum_q;
	logic [7:0]            tx_sum_d;
	logic                  rx_ready_q;
	logic                  exec_req_q;
	logic                  exec_req_d;
	logic                  busy_q;
	logic                  rx_take;
	logic                  rx_last;
	logic [3:0]            body_pos;
	logic [3:0]            tx_last_idx;
	logic [3:0]            ridx;
	logic [7:0]            tx_byte;
	logic                  push;
	logic                  buf_in_ready;
	logic                  addr_miss;
	logic                  sum_bad;

	// ----------------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------------
	// Lengths follow the link kind; can_mode must stay steady during a frame
	assign rx_take     = rx_valid && rx_ready_q;
	assign rx_last     = rx_take && (rx_pos_q == (can_mode ? `MCFH_CAN_LEN - 4'h1 : `MCFH_SER_LEN - 4'h1)); // (R2)
	assign body_pos    = can_mode ? rx_pos_q : rx_pos_q - 4'h1; // (R4)
	assign tx_last_idx = can_mode ? `MCFH_CAN_RLEN - 4'h1 : `MCFH_SER_RLEN - 4'h1; // (R9)
	assign ridx        = can_mode ? tx_idx_q + `MCFH_CAN_RSKIP : tx_idx_q;
	assign addr_miss   = !can_mode && (addr_q != own_addr); // (R15)
	assign sum_bad     = !can_mode && (rx_data != rx_sum_q); // (R3)
	assign push        = (state_q == mcfh_pkg::MCFH_TX) && buf_in_ready; // (R11)

	// Reply byte in serial order; CAN starts two bytes in
	always_comb
	begin
		unique case (ridx)
			4'h0:    tx_byte = reply_addr; // (R7)
			4'h1:    tx_byte = own_addr;
			4'h2:    tx_byte = rsp_q.status;
			4'h3:    tx_byte = cmd_q.cmd; // (R14)
			4'h4:    tx_byte = rsp_q.value[31:24];
			4'h5:    tx_byte = rsp_q.value[23:16];
			4'h6:    tx_byte = rsp_q.value[15:8];
			4'h7:    tx_byte = rsp_q.value[7:0];
			4'h8:    tx_byte = tx_sum_q; // (R8)
			default: tx_byte = `MCFH_RST_BYTE;
		endcase
	end

	// ----------------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------------
	// Receive, hand to executor, frame reply
	always_comb
	begin
		state_d    = state_q;
		cmd_d      = cmd_q;
		rsp_d      = rsp_q;
		rx_pos_d   = rx_pos_q;
		rx_sum_d   = rx_sum_q;
		addr_d     = addr_q;
		tx_idx_d   = tx_idx_q;
		tx_sum_d   = tx_sum_q;
		exec_req_d = 1'b0;
		unique case (state_q)
			mcfh_pkg::MCFH_RX:
			begin
				if (rx_take)
				begin
					rx_pos_d = rx_pos_q + 4'h1;
					rx_sum_d = rx_sum_q + rx_data;
					if (!can_mode && (rx_pos_q == `MCFH_POS_ADDR))
					begin
						addr_d = rx_data;
					end
					// Body bytes; value arrives MSB first
					unique case (body_pos)
						4'h0:    cmd_d.cmd          = rx_data; // (R1)
						4'h1:    cmd_d.kind         = rx_data;
						4'h2:    cmd_d.bank         = rx_data;
						4'h3:    cmd_d.value[31:24] = rx_data;
						4'h4:    cmd_d.value[23:16] = rx_data;
						4'h5:    cmd_d.value[15:8]  = rx_data;
						4'h6:    cmd_d.value[7:0]   = rx_data;
						default: cmd_d.value        = cmd_q.value;
					endcase
				end
				if (rx_last)
				begin
					rx_pos_d = 4'h0;
					rx_sum_d = `MCFH_RST_BYTE;
					if (addr_miss)
					begin
						state_d = mcfh_pkg::MCFH_RX; // (R15)
					end
					else if (sum_bad)
					begin
						// Bad frames still answer, but nothing is executed
						rsp_d.status = `MCFH_ST_BAD_SUM; // (R10)
						rsp_d.value  = `MCFH_RST_WORD;
						state_d      = mcfh_pkg::MCFH_TX; // (R5)
					end
					else
					begin
						exec_req_d = 1'b1;
						state_d    = mcfh_pkg::MCFH_EXEC;
					end
				end
			end
			mcfh_pkg::MCFH_EXEC:
			begin
				if (exec_done)
				begin
					rsp_d   = exec_rsp; // (R10)
					state_d = mcfh_pkg::MCFH_TX; // (R6)
				end
			end
			mcfh_pkg::MCFH_TX:
			begin
				if (push)
				begin
					tx_idx_d = tx_idx_q + 4'h1;
					tx_sum_d = tx_sum_q + tx_byte; // (R8)
					if (tx_idx_q == tx_last_idx)
					begin
						tx_idx_d = 4'h0;
						tx_sum_d = `MCFH_RST_BYTE;
						state_d  = mcfh_pkg::MCFH_RX;
					end
				end
			end
			default:
			begin
				state_d = mcfh_pkg::MCFH_RX;
			end
		endcase
	end

	// Register stage; link is held off while a command is outstanding
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_q    <= mcfh_pkg::MCFH_RX;
			cmd_q      <= '0;
			rsp_q      <= '0;
			rx_pos_q   <= 4'h0;
			rx_sum_q   <= `MCFH_RST_BYTE;
			addr_q     <= `MCFH_RST_BYTE;
			tx_idx_q   <= 4'h0;
			tx_sum_q   <= `MCFH_RST_BYTE;
			rx_ready_q <= 1'b0;
			exec_req_q <= 1'b0;
			busy_q     <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cmd_q      <= cmd_d;
			rsp_q      <= rsp_d;
			rx_pos_q   <= rx_pos_d;
			rx_sum_q   <= rx_sum_d;
			addr_q     <= addr_d;
			tx_idx_q   <= tx_idx_d;
			tx_sum_q   <= tx_sum_d;
			rx_ready_q <= (state_d == mcfh_pkg::MCFH_RX); // (R13)
			exec_req_q <= exec_req_d;
			busy_q     <= (state_d != mcfh_pkg::MCFH_RX);
		end
	end

	assign rx_ready = rx_ready_q;
	assign exec_req = exec_req_q;
	assign exec_cmd = cmd_q;
	assign busy     = busy_q;

	// ----------------------------------------------------------------------
	// Reply buffer
	// ----------------------------------------------------------------------
	// Receiver stalls back up into the framer, so no byte is lost
	mcfh_buf
	#(
		.WIDTH (8),
		.DEPTH (2)
	)
	u_buf
	(
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_data   (tx_byte),
		.in_ready  (buf_in_ready),
		.out_valid (tx_valid),
		.out_data  (tx_data),
		.out_ready (tx_ready)
	);

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	a_exec_single: assert property (@(posedge clock) disable iff (sys_rst) // (R5)
		exec_req_q |-> (state_q == mcfh_pkg::MCFH_EXEC) ##1 !exec_req_q)
		else $error("executor request not a single pulse");

	a_wait_exec: assert property (@(posedge clock) disable iff (sys_rst) // (R6)
		(state_q == mcfh_pkg::MCFH_EXEC && !exec_done) |=> (state_q == mcfh_pkg::MCFH_EXEC))
		else $error("reply started before execution finished");

	a_push_reply: assert property (@(posedge clock) disable iff (sys_rst) // (R11)
		push |-> !rx_ready_q)
		else $error("byte queued while receiver open");

	a_reply_len: assert property (@(posedge clock) disable iff (sys_rst) // (R7)
		(state_q == mcfh_pkg::MCFH_TX && state_d == mcfh_pkg::MCFH_RX)
		|-> (tx_idx_q == (can_mode ? 4'h5 : 4'h8)))
		else $error("reply length wrong");

	a_reply_sum: assert property (@(posedge clock) disable iff (sys_rst) // (R8)
		(push && !can_mode && tx_idx_q == `MCFH_POS_SUM)
		|-> (tx_byte == 8'(reply_addr + own_addr + rsp_q.status + cmd_q.cmd
			+ rsp_q.value[31:24] + rsp_q.value[23:16] + rsp_q.value[15:8] + rsp_q.value[7:0])))
		else $error("reply checksum byte wrong");

	a_cmd_echo: assert property (@(posedge clock) disable iff (sys_rst) // (R14)
		(push && ridx == 4'h3) |-> (tx_byte == cmd_q.cmd) && $stable(cmd_q))
		else $error("command number not echoed");

	a_bad_sum: assert property (@(posedge clock) disable iff (sys_rst) // (R3)
		(rx_last && !can_mode && addr_q == own_addr && rx_data != rx_sum_q)
		|=> (state_q == mcfh_pkg::MCFH_TX) && (rsp_q.status == `MCFH_ST_BAD_SUM) && !exec_req_q)
		else $error("checksum error not answered");

	a_addr_drop: assert property (@(posedge clock) disable iff (sys_rst) // (R15)
		(rx_last && !can_mode && addr_q != own_addr) |=> ((state_q == mcfh_pkg::MCFH_RX) && !exec_req_q) [*2])
		else $error("foreign frame not dropped");

	a_rx_stall: assert property (@(posedge clock) disable iff (sys_rst) // (R13)
		(state_q != mcfh_pkg::MCFH_RX) |-> !rx_ready_q)
		else $error("receiver open while busy");

	a_good_exec: assert property (@(posedge clock) disable iff (sys_rst) // (R4)
		(rx_last && can_mode) |=> exec_req_q && (state_q == mcfh_pkg::MCFH_EXEC))
		else $error("CAN frame not executed");

endmodule // mcfh_top

/* File: sim/mcfh_host.sv */
// Host model: sends command frames and sinks reply bytes
`timescale 1ns/1ns

module mcfh_host
(
	input  wire logic       clock,
	input  wire logic       rx_ready,
	input  wire logic [1:0] mode,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_ready
);
	logic [2:0] cnt_q = 3'h0;

	// Sink: 0 always ready, 1 stalls three of eight cycles, 2 holds off
	always @(posedge clock)
	begin
		cnt_q    <= cnt_q + 3'h1;
		tx_ready <= (mode == 2'h0) || (mode == 2'h1 && cnt_q > 3'h2);
	end

	// Idle until the bench asks for a frame
	initial
	begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
	end

	// Host alone opens an exchange; bytes held until taken, MSB first
	task automatic send(input logic [71:0] f, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			rx_valid <= 1'b1;
			rx_data  <= f[71-8*i -: 8];
			@(posedge clock);
			while (rx_ready !== 1'b1)
				@(posedge clock);
		end
		// Released line shows junk, not the last byte
		rx_valid <= 1'b0;
		rx_data  <= ~f[79-8*n -: 8];
	endtask
endmodule // mcfh_host

/* File: sim/tb.sv */
// Self-checking bench for the command frame handler
`timescale 1ns/1ns

module tb;
	logic                clock        = 1'b0;
	logic                sys_rst      = 1'b1;
	logic                can_mode     = 1'b0;
	logic [7:0]          own_addr     = 8'h00;
	logic [7:0]          reply_addr   = 8'h00;
	logic                rx_valid;
	logic [7:0]          rx_data;
	logic                rx_ready;
	logic                exec_req;
	mcfh_pkg::mcfh_cmd_t exec_cmd;
	logic                exec_done    = 1'b0;
	mcfh_pkg::mcfh_rsp_t exec_rsp     = 40'h0;
	logic                tx_valid;
	logic [7:0]          tx_data;
	logic                tx_ready;
	logic                busy;
	logic [1:0]          mode         = 2'h0;
	logic [15:0]         seed         = 16'ha9cb;
	logic [7:0]          exp_q[$];
	mcfh_pkg::mcfh_cmd_t exp_cmd;
	logic [7:0]          rsp_status;
	logic [31:0]         rsp_val;
	logic                ex_busy      = 1'b0;
	logic [7:0]          codes[7]     = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
	int                  n_exec       = 0;
	int                  n_exp_exec   = 0;
	int                  n_mismatch   = 0;
	int                  total_checks = 0;

	always #10 clock = ~clock;

	mcfh_top i_mcfh_top (.clock(clock), .sys_rst(sys_rst), .can_mode(can_mode), .own_addr(own_addr),
		.reply_addr(reply_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.exec_req(exec_req), .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_rsp(exec_rsp),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy));

	mcfh_host i_mcfh_host (.clock(clock), .rx_ready(rx_ready), .mode(mode), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_ready(tx_ready));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function logic [15:0] rand16();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Expected reply; CAN drops both addresses and the sum
	task automatic push_reply(input logic [7:0] st, input logic [7:0] c, input logic [31:0] v);
		logic [63:0] w;
		logic [7:0]  s;
		int          k;
		w = {reply_addr, own_addr, st, c, v};
		s = 8'h00;
		for (k = 0; k < 8; k++)
		begin
			s += w[63-8*k -: 8];
			if (!can_mode || k >= 2)
				exp_q.push_back(w[63-8*k -: 8]);
		end
		if (!can_mode)
			exp_q.push_back(s);
	endtask

	// Host must see the whole reply before the next command
	task automatic wait_reply();
		int k;
		for (k = 0; k < 300; k++)
		begin
			@(posedge clock);
			if (rx_ready === 1'b1 && exp_q.size() == 0 && !ex_busy)
				break;
		end
		check(k < 300, "reply not finished in time");
	endtask

	// One exchange: build frame, note expectations, send, wait
	task automatic run(input logic [7:0] addr, input logic bad_sum, input logic [7:0] st);
		logic [71:0] f;
		logic [63:0] r;
		logic [7:0]  sum;
		int          k;
		r          = {rand16(), rand16(), rand16(), rand16()};
		exp_cmd    = r[55:0];
		rsp_status = st;
		f          = {addr, exp_cmd, 8'h00};
		sum        = 8'h00;
		for (k = 0; k < 8; k++)
			sum += f[71-8*k -: 8];
		f[7:0] = sum + {7'h0, bad_sum};
		if (can_mode)
			f = {exp_cmd, 16'h0000};
		if (!can_mode && bad_sum && addr == own_addr)
			push_reply(8'h01, exp_cmd.cmd, 32'h0);
		else if (can_mode || addr == own_addr)
			n_exp_exec++;
		i_mcfh_host.send(f, can_mode ? 7 : 9);
		wait_reply();
	endtask

	// ------------------------------------------------------------
	// Executor stand-in and scoreboard
	// ------------------------------------------------------------
	// Answers after 0..3 cycles; reply noted only then, so an early reply fails
	initial
	forever
	begin
		@(posedge clock);
		if (exec_req === 1'b1)
		begin
			ex_busy = 1'b1;
			n_exec++;
			check(exec_cmd === exp_cmd, "decoded command");
			repeat (int'(rand16() & 16'h3)) @(posedge clock);
			rsp_val = {rand16(), rand16()};
			exec_done <= 1'b1;
			exec_rsp  <= {rsp_status, rsp_val};
			push_reply(rsp_status, exp_cmd.cmd, rsp_val);
			@(posedge clock);
			exec_done <= 1'b0;
			ex_busy = 1'b0;
		end
		else
			exec_rsp <= ~exec_rsp;
	end

	// Every byte taken is compared with the oldest note
	always @(posedge clock)
		if (sys_rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(1'b0, "reply byte nobody asked for");
			else
				check(tx_data === exp_q.pop_front(), "reply byte");
		end

	// Hang guard, far above the expected run length
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		own_addr   <= 8'(rand16());
		reply_addr <= 8'(rand16());
		repeat (5) @(posedge clock);
		check(rx_ready === 1'b0 && tx_valid === 1'b0 && busy === 1'b0, "outputs in reset");
		sys_rst <= 1'b0;
		mode    <= 2'h1;
		foreach (codes[i])
			run(own_addr, 1'b0, codes[i]);
		run(own_addr, 1'b1, 8'h64);
		run(own_addr ^ 8'h5a, 1'b1, 8'h64);
		run(own_addr ^ 8'h01, 1'b0, 8'h64);
		can_mode <= 1'b1;
		@(posedge clock);
		run(own_addr, 1'b0, 8'h65);
		run(own_addr, 1'b0, 8'h02);
		// Receiver holds off: buffer fills, framer must wait and lose nothing
		mode <= 2'h2;
		fork
			begin
				repeat (40) @(posedge clock);
				check(rx_ready === 1'b0 && busy === 1'b1, "stalled reply");
				mode <= 2'h0;
			end
		join_none
		run(own_addr, 1'b0, 8'h64);
		check(n_exec === n_exp_exec, "executor call count");
		check(exp_q.size() == 0, "reply bytes missing");
		report_and_stop();
	end
endmodule // tb
